/* File: mss_params.svh */
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// APB register byte offsets
`define MSS_CFG_OFF        12'h000
`define MSS_STAT_OFF       12'h004
`define MSS_SCNT_OFF       12'h008

// Configuration register fields
`define MSS_CFG_RANGE_LSB  0
`define MSS_CFG_FMOD_LSB   8
`define MSS_CFG_SMOD_LSB   16
`define MSS_CFG_TYPE_BIT   24
`define MSS_CFG_RST        32'h0000_0000

// Status register fields
`define MSS_STAT_FHIT_BIT  0
`define MSS_STAT_FSEL_LSB  4
`define MSS_STAT_SREQ_BIT  8
`define MSS_STAT_SSEL_LSB  12

// Address bit positions
`define MSS_RANGE_LSB      13
`define MSS_BIP_PAIR_LSB   11
`define MSS_MOS_PAIR_LSB   13

// Field widths
`define MSS_RANGE_W        5
`define MSS_MOD_W          4

`endif

/* File: mss_pkg.sv */
`include "mss_params.svh"

package mss_pkg;

  typedef enum logic {
    MSS_MOS,
    MSS_BIPOLAR
  } mss_mem_t;

  typedef logic [`MSS_RANGE_W-1:0] mss_range_t;
  typedef logic [`MSS_MOD_W-1:0]   mss_mod_t;

  // Module-select address pair for the configured storage type
  function automatic logic [1:0] mss_pair(input logic [17:0] addr, input mss_mem_t t);
    if (t == MSS_BIPOLAR) begin
      return addr[`MSS_BIP_PAIR_LSB +: 2]; // R06
    end
    return addr[`MSS_MOS_PAIR_LSB +: 2];
  endfunction : mss_pair

endpackage : mss_pkg

/* File: mss_addr_decode.sv */
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_addr_decode
  import mss_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire mss_range_t        range_straps,
  input  wire mss_mod_t          module_straps,
  input  wire mss_mem_t          mem_type,
  output logic                   hit,
  output mss_mod_t               module_sel
);

  generate
    if (ADDR_W != 18) begin : g_bad_width
      $error("mss_addr_decode: ADDR_W must be 18");
    end
  endgenerate

  logic [1:0]             pair;
  logic [`MSS_RANGE_W-1:0] range_ok;
  logic [`MSS_MOD_W-1:0]   mod_ok;

  always_comb begin // R18
    pair = mss_pair(addr[17:0], mem_type); // R12
    for (int i = 0; i < `MSS_RANGE_W; i++) begin // R15
      range_ok[i] = (addr[`MSS_RANGE_LSB + i] == range_straps[i]); // R09
    end
    // Bits 14 and 13 need no range-strap match for MOS storage
    if (mem_type == MSS_MOS) begin
      range_ok[1:0] = 2'h3; // R11
    end
    for (int k = 0; k < `MSS_MOD_W; k++) begin
      mod_ok[k] = module_straps[k] | (pair != 2'(k)); // R10
    end
    hit        = (&range_ok) & (&mod_ok); // R08
    module_sel = hit ? (4'h1 << pair) : 4'h0; // R04
  end

endmodule : mss_addr_decode

/* File: mss_select_decoder.sv */
`timescale 1ns/1ps
`include "mss_params.svh"

// Functional notes
// (R01) Address bits 11-17 decide controller response
// (R02) Bits 17,16 pick one 32K section
// (R03) Bit 15 picks 16K group, this controller
// (R04) MOS: bits 14,13 select MOS module
// (R05) Bipolar: bits 14,13 place 4K block
// (R06) Bipolar: bits 12,11 select 1K module
// (R07) Accepted fast address returns active-low acknowledge
// (R08) Valid equals AND of nine terms
// (R09) Removed strap needs 1, fitted needs 0
// (R10) Module term passes if removed or outside
// (R11) MOS ignores range straps for 14,13
// (R12) Module pair: 12,11 bipolar; 14,13 MOS
// (R13) One removed module strap per sub-range
// (R14) Range straps place block; module straps assign
// (R15) Range straps map to bits 17..13
// (R16) System decoder shares range, own module straps
// (R17) System hit plus sync strobe requests cycle
// (R18) Straps static; decode follows stable address
// (R19) Memory type switches module-select pair
module mss_select_decoder
  import mss_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [ADDR_W-1:0] fast_addr,
  input  wire logic [ADDR_W-1:0] sys_addr,
  input  wire logic              master_sync_strobe_n,
  output logic                   valid_address_ack_n,
  output mss_mod_t               fast_module_sel,
  output logic                   cycle_request_n,
  output mss_mod_t               sys_module_sel
);

  generate
    if (ADDR_W != 18) begin : g_bad_width
      $error("mss_select_decoder: ADDR_W must be 18");
    end
  endgenerate

  // Strap registers and bus state
  mss_range_t  range_r,  range_nxt;
  mss_mod_t    fmod_r,   fmod_nxt;
  mss_mod_t    smod_r,   smod_nxt;
  mss_mem_t    mtype_r,  mtype_nxt;
  logic [31:0] scnt_r,   scnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        perr_r,   perr_nxt;

  // Decode outputs
  logic        ack_n_r,  ack_n_nxt;
  mss_mod_t    fsel_r,   fsel_nxt;
  logic        req_n_r,  req_n_nxt;
  mss_mod_t    ssel_r,   ssel_nxt;

  logic        fast_hit;
  mss_mod_t    fast_sel;
  logic        sys_hit;
  mss_mod_t    sys_sel;
  logic        wr_en;
  logic        mapped;

  // Fast-bus decoder
  mss_addr_decode #(
    .ADDR_W        (ADDR_W)
  ) u_fast_dec (
    .addr          (fast_addr), // R01
    .range_straps  (range_r), // R02
    .module_straps (fmod_r),
    .mem_type      (mtype_r), // R05
    .hit           (fast_hit), // R03
    .module_sel    (fast_sel)
  );

  // System-bus decoder shares range straps
  mss_addr_decode #(
    .ADDR_W        (ADDR_W)
  ) u_sys_dec (
    .addr          (sys_addr),
    .range_straps  (range_r), // R16
    .module_straps (smod_r), // R16
    .mem_type      (mtype_r),
    .hit           (sys_hit),
    .module_sel    (sys_sel)
  );

  // Decode result registering
  always_comb begin
    ack_n_nxt = ~fast_hit; // R07
    fsel_nxt  = fast_sel;
    req_n_nxt = ~(sys_hit & ~master_sync_strobe_n); // R17
    ssel_nxt  = sys_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_n_r <= 1'b1;
      fsel_r  <= 4'h0;
      req_n_r <= 1'b1;
      ssel_r  <= 4'h0;
    end else begin
      ack_n_r <= ack_n_nxt;
      fsel_r  <= fsel_nxt;
      req_n_r <= req_n_nxt;
      ssel_r  <= ssel_nxt;
    end
  end

  // APB slave, zero wait states
  always_comb begin
    mapped = (paddr == `MSS_CFG_OFF) || (paddr == `MSS_STAT_OFF) ||
             (paddr == `MSS_SCNT_OFF);
    wr_en      = psel & penable & pready_r & pwrite & ~perr_r;
    range_nxt  = range_r;
    fmod_nxt   = fmod_r;
    smod_nxt   = smod_r;
    mtype_nxt  = mtype_r;
    scnt_nxt   = scnt_r;
    pready_nxt = psel & ~penable;
    perr_nxt   = psel & ~penable & ~mapped;
    prdata_nxt = prdata_r;
    // Count each new system cycle request unless a counter write clears in that cycle
    if (req_n_r && !req_n_nxt) begin
      scnt_nxt = scnt_r + 32'h0000_0001;
    end
    if (wr_en && paddr == `MSS_CFG_OFF) begin
      if (pstrb[0]) begin
        range_nxt = pwdata[`MSS_CFG_RANGE_LSB +: `MSS_RANGE_W]; // R14
      end
      if (pstrb[1]) begin
        fmod_nxt = pwdata[`MSS_CFG_FMOD_LSB +: `MSS_MOD_W]; // R13
      end
      if (pstrb[2]) begin
        smod_nxt = pwdata[`MSS_CFG_SMOD_LSB +: `MSS_MOD_W];
      end
      if (pstrb[3]) begin
        mtype_nxt = mss_mem_t'(pwdata[`MSS_CFG_TYPE_BIT]); // R19
      end
    end
    // Write to the counter clears it
    if (wr_en && paddr == `MSS_SCNT_OFF) begin
      scnt_nxt = 32'h0000_0000;
    end
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `MSS_CFG_OFF: begin
            prdata_nxt[`MSS_CFG_RANGE_LSB +: `MSS_RANGE_W] = range_r;
            prdata_nxt[`MSS_CFG_FMOD_LSB +: `MSS_MOD_W]    = fmod_r;
            prdata_nxt[`MSS_CFG_SMOD_LSB +: `MSS_MOD_W]    = smod_r;
            prdata_nxt[`MSS_CFG_TYPE_BIT]                  = mtype_r;
          end
          `MSS_STAT_OFF: begin
            prdata_nxt[`MSS_STAT_FHIT_BIT]             = ~ack_n_r;
            prdata_nxt[`MSS_STAT_FSEL_LSB +: `MSS_MOD_W] = fsel_r;
            prdata_nxt[`MSS_STAT_SREQ_BIT]             = ~req_n_r;
            prdata_nxt[`MSS_STAT_SSEL_LSB +: `MSS_MOD_W] = ssel_r;
          end
          `MSS_SCNT_OFF: begin
            prdata_nxt = scnt_r;
          end
          default: begin
            prdata_nxt = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_r  <= `MSS_RANGE_W'(`MSS_CFG_RST);
      fmod_r   <= 4'h0;
      smod_r   <= 4'h0;
      mtype_r  <= MSS_MOS;
      scnt_r   <= 32'h0000_0000;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      perr_r   <= 1'b0;
    end else begin
      range_r  <= range_nxt;
      fmod_r   <= fmod_nxt;
      smod_r   <= smod_nxt;
      mtype_r  <= mtype_nxt;
      scnt_r   <= scnt_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      perr_r   <= perr_nxt;
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = perr_r;
  assign valid_address_ack_n = ack_n_r;
  assign fast_module_sel     = fsel_r;
  assign cycle_request_n     = req_n_r;
  assign sys_module_sel      = ssel_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_section_match: assert property ( // R02
    !valid_address_ack_n |-> $past(fast_addr[17:16]) == $past(range_r[4:3]))
    else $error("ack with section bits not matching straps");

  chk_group_match: assert property ( // R03
    !valid_address_ack_n |-> $past(fast_addr[15]) == $past(range_r[2]))
    else $error("ack with bit 15 not matching strap");

  chk_off_range_no_ack: assert property ( // R01
    $past(fast_addr[17:15]) != $past(range_r[4:2]) |-> valid_address_ack_n)
    else $error("ack for address outside range");

  chk_bip_block: assert property ( // R05
    !valid_address_ack_n && $past(mtype_r) == MSS_BIPOLAR
      |-> $past(fast_addr[14:13]) == $past(range_r[1:0]))
    else $error("bipolar block bits 14,13 not matched");

  chk_mos_module: assert property ( // R04
    !valid_address_ack_n && $past(mtype_r) == MSS_MOS
      |-> fast_module_sel == (4'h1 << $past(fast_addr[14:13])))
    else $error("MOS module select wrong");

  chk_bip_module: assert property ( // R06
    !valid_address_ack_n && $past(mtype_r) == MSS_BIPOLAR
      |-> fast_module_sel == (4'h1 << $past(fast_addr[12:11])))
    else $error("bipolar module select wrong");

  chk_module_strap: assert property ( // R10
    !valid_address_ack_n |-> (fast_module_sel & $past(fmod_r)) != 4'h0)
    else $error("ack for module whose strap is fitted");

  chk_ack_exact: assert property ( // R08
    valid_address_ack_n == !$past(fast_hit) && $onehot0(fast_module_sel))
    else $error("ack does not follow decode");

  chk_mod_pair: assert property ( // R12
    !valid_address_ack_n
      |-> fast_module_sel == (4'h1 << mss_pair($past(fast_addr[17:0]), $past(mtype_r))))
    else $error("module pair source wrong");

  chk_sys_request: assert property ( // R17
    !cycle_request_n |-> $past(!master_sync_strobe_n) && $past(sys_hit)
      && $past(sys_addr[17:15]) == $past(range_r[4:2]))
    else $error("request without sync strobe and hit");

  chk_apb_ready: assert property (
    psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase without ready");

  cov_fast_mos: cover property (!valid_address_ack_n && mtype_r == MSS_MOS);
  cov_fast_bip: cover property (!valid_address_ack_n && mtype_r == MSS_BIPOLAR);
  cov_sys_req:  cover property ($fell(cycle_request_n));
  cov_cfg_wr:   cover property (wr_en && paddr == `MSS_CFG_OFF);

endmodule : mss_select_decoder

/* File: mss_bus_master.sv */
`timescale 1ns/1ps
module mss_bus_master (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [17:0] f_req,
  input  wire logic [17:0] s_req,
  input  wire logic        s_go,
  output logic      [17:0] fast_addr,
  output logic      [17:0] sys_addr,
  output logic             master_sync_strobe_n
);
  // Launch just after an edge, hold a full cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_addr            <= 18'h00000;
      sys_addr             <= 18'h00000;
      master_sync_strobe_n <= 1'b1;
    end else begin
      fast_addr            <= f_req;
      sys_addr             <= s_req;
      master_sync_strobe_n <= ~s_go;
    end
  end
endmodule : mss_bus_master

/* File: mss_select_decoder_bench.sv */
`timescale 1ns/1ps
`include "mss_params.svh"
module mss_select_decoder_bench;
  import mss_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [3:0]  strb    = 4'hF;
  logic [31:0] prdata, seed, cfg, rd;
  logic        pready, pslverr, er, s_go, strobe_n, ack_n, req_n;
  logic [17:0] f_req, s_req, fast_addr, sys_addr, fa, sa;
  mss_mod_t    fsel, ssel;
  int          err_count, total_checks, cycles;

  always #4 pclk = ~pclk;

  mss_bus_master u_master (.pclk(pclk), .presetn(presetn), .f_req(f_req), .s_req(s_req),
    .s_go(s_go), .fast_addr(fast_addr), .sys_addr(sys_addr), .master_sync_strobe_n(strobe_n));

  mss_select_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fast_addr(fast_addr), .sys_addr(sys_addr),
    .master_sync_strobe_n(strobe_n), .valid_address_ack_n(ack_n),
    .fast_module_sel(fsel), .cycle_request_n(req_n), .sys_module_sel(ssel));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
  endfunction : lfsr

  // Returns {hit, one-hot module}
  function automatic logic [4:0] want(input logic [17:0] a, input logic [31:0] c,
                                      input int base);
    logic [1:0] p;
    logic       ok;
    p  = c[24] ? a[12:11] : a[14:13];
    ok = c[base + p];
    for (int i = 0; i < 5; i++)
      if (c[24] || i > 1) ok &= (a[13 + i] == c[i]);
    return ok ? {1'b1, 4'h1 << p} : 5'h00;
  endfunction : want

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= wr ? strb : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic drive(input logic [17:0] a, input logic [17:0] b, input logic go);
    logic [4:0] fw, sw;
    fw = want(a, cfg, 8);
    sw = want(b, cfg, 16);
    @(posedge pclk);
    f_req <= a;
    s_req <= b;
    s_go  <= go;
    repeat (2) @(posedge pclk);
    #1;
    chk(ack_n, !fw[4], "fast ack");
    chk(fsel, fw[3:0], "fast module");
    chk(req_n, !(sw[4] && go), "cycle request");
    chk(ssel, sw[3:0], "sys module");
  endtask : drive

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    f_req = 18'h00000;
    s_req = 18'h00000;
    s_go  = 1'b0;
    cfg   = 32'h0;
    seed  = 32'hD1AB;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MSS_CFG_OFF, 32'h0);
    chk(rd, `MSS_CFG_RST, "config reset");
    apb(1'b0, 12'h00C, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    drive(18'h00000, 18'h00000, 1'b1);
    $display("reset test done");
    for (int t = 0; t < 150; t++) begin
      seed = lfsr(seed);
      cfg  = seed & 32'h010F_0F1F;
      if (t == 0) cfg = 32'h010F_0F1F;
      if (t == 1) cfg = 32'h000F_0F03;
      apb(1'b1, `MSS_CFG_OFF, cfg);
      apb(1'b0, `MSS_CFG_OFF, 32'h0);
      chk(rd, cfg, "config readback");
      repeat (4) begin
        seed = lfsr(seed);
        fa   = seed[17:0];
        if (seed[31]) fa[17:13] = cfg[4:0];
        seed = lfsr(seed);
        sa   = seed[17:0];
        if (seed[31]) sa[17:13] = cfg[4:0];
        drive(fa, sa, seed[20]);
      end
    end
    $display("decode test done");
    cfg = 32'h010F_0F1F;
    apb(1'b1, `MSS_CFG_OFF, cfg);
    drive(18'h00000, 18'h00000, 1'b0);
    apb(1'b1, `MSS_SCNT_OFF, 32'h0);
    drive(18'h3E000, 18'h3E000, 1'b1);
    apb(1'b0, `MSS_STAT_OFF, 32'h0);
    chk(rd, 32'h0000_1111, "status");
    drive(18'h3E000, 18'h3E000, 1'b0);
    drive(18'h3E000, 18'h3E000, 1'b1);
    drive(18'h00000, 18'h00000, 1'b0);
    apb(1'b0, `MSS_SCNT_OFF, 32'h0);
    chk(rd, 32'h0000_0002, "request count");
    $display("counter test done");
    strb = 4'h1;
    apb(1'b1, `MSS_CFG_OFF, 32'h0000_0002);
    strb = 4'hF;
    apb(1'b1, `MSS_STAT_OFF, 32'hFFFF_FFFF);
    chk(er, 1'b0, "status write");
    apb(1'b0, `MSS_CFG_OFF, 32'h0);
    chk(rd, 32'h010F_0F02, "lane write");
    $display("register test done");
    complete_run();
  end
endmodule : mss_select_decoder_bench
